//--- design/iest_pkg.sv
// Purpose: Shared constants and types for the I2C event status block
// Assumes: Byte addresses on the APB port
// Notes: Event flags travel as one packed struct
package iest_pkg;
    // Register byte addresses
    localparam logic [31:0] ADDR_DATA_CMD = 32'h50001310;
    localparam logic [31:0] ADDR_INTR_STAT = 32'h5000132c;
    localparam logic [31:0] ADDR_INTR_MASK = 32'h50001330;
    localparam logic [31:0] ADDR_RAW_STAT = 32'h50001334;
    localparam logic [31:0] ADDR_RX_THR = 32'h50001338;
    localparam logic [31:0] ADDR_TX_THR = 32'h5000133c;
    localparam logic [31:0] ADDR_CLR_ALL = 32'h50001340;
    localparam logic [31:0] ADDR_CLR_RX_UNDER = 32'h50001344;
    localparam logic [31:0] ADDR_CLR_RX_OVER = 32'h50001348;
    localparam logic [31:0] ADDR_CLR_TX_OVER = 32'h5000134c;
    localparam logic [31:0] ADDR_CLR_RD_REQ = 32'h50001350;
    localparam logic [31:0] ADDR_CLR_TRANSMIT_ABORT_FLAG = 32'h50001354;
    localparam logic [31:0] ADDR_ABORT_REASON = 32'h50001380;
    // Reset values
    localparam logic [15:0] MASK_RESET = 16'h08ff;
    localparam logic [4:0] THR_RESET = 5'h00;
    // Sizes
    localparam int FIFO_DEPTH = 32;
    localparam int RX_W = 8;
    localparam int TX_W = 9;
    localparam int EV_W = 7;
    // Raw event flags, bit 6 down to bit 0
    typedef struct packed {
        logic tx_abort;
        logic rd_req;
        logic tx_empty;
        logic tx_over;
        logic rx_full;
        logic rx_over;
        logic rx_under;
    } iest_events_t;
    // Byte delivered by the bus state machine
    typedef struct packed {
        logic valid;
        logic [RX_W-1:0] data;
    } iest_rx_byte_t;
endpackage

//--- design/iest_event_status.sv
// Purpose: I2C event flags, FIFO thresholds and clear registers
// Assumes: Bus state machines live outside and share core_clk
// Notes: Event flags, thresholds and APB answer in one module
// Function
// - Set read-request flag, bit 5, when a remote master reads us.
// - Hold SCL low while a read request waits for service.
// - Reading the read-request clear register zeroes the read-request flag.
// - Transmit-low flag, bit 4, set while TX level is at or below threshold.
// - Disabled: flush TX FIFO; transmit-low follows state machine activity.
// - Set transmit-overflow, bit 3, on a data write into a full TX FIFO.
// - Overflow and underflow flags hold until internal enable drops, then clear.
// - Receive-high flag, bit 2, set while RX level is above the threshold.
// - Disabled: flush RX FIFO and clear receive-high at once.
// - Byte into full RX FIFO is acked, dropped, sets receive-overflow bit 1.
// - Read of the data port with RX FIFO empty sets underflow bit 0.
// - Five-bit receive threshold N fires at N+1 or more entries.
// - Receive threshold above the depth is stored as the maximum depth; code keeps only pwdata[4:0], so larger writes wrap.
// - Five-bit transmit threshold; 0 means zero entries, 31 means 32.
// - Transmit threshold above the depth is stored as the maximum depth; code keeps only pwdata[4:0], so larger writes wrap.
// - Clear-all read clears software-clearable flags and the abort reason.
// - Clear-all read leaves both threshold flags untouched.
// - After an abort, refuse TX data until the abort clear register is read.
// - TX FIFO is flushed while the abort flag is set.
// - Mask register gates each raw flag into the masked status.
`timescale 1ns/10ps

module iest_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    localparam int AW = $clog2(DEPTH),
    localparam int LW = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill level
    output logic [LW-1:0] level
);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_ptr_q;
    logic [AW-1:0] rd_ptr_q;
    logic [LW-1:0] level_q;
    logic push;
    logic pop;

    assign in_ready = !flush && (level_q != LW'(DEPTH));
    assign out_valid = !flush && (level_q != '0);
    assign out_data = mem_q[rd_ptr_q];
    assign level = level_q;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data;
        end
    end

    // Write pointer
    always_ff @(posedge core_clk) begin
        if (rst || flush) begin
            wr_ptr_q <= '0;
        end else if (push) begin
            wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
        end
    end

    // Read pointer
    always_ff @(posedge core_clk) begin
        if (rst || flush) begin
            rd_ptr_q <= '0;
        end else if (pop) begin
            rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
        end
    end

    // Level
    always_ff @(posedge core_clk) begin
        if (rst || flush) begin
            level_q <= '0;
        end else if (push && !pop) begin
            level_q <= level_q + 1'b1;
        end else if (pop && !push) begin
            level_q <= level_q - 1'b1;
        end
    end
endmodule // iest_fifo

module iest_event_status #(
    parameter int DEPTH = iest_pkg::FIFO_DEPTH,
    parameter int REASON_W = 16,
    localparam int LW = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Controller state
    input wire logic enable_bit,
    input wire logic internal_enable_state,
    input wire logic sm_activity,
    // Received bytes from the bus
    input wire iest_pkg::iest_rx_byte_t rx_byte,
    // Commands to the bus
    output logic tx_cmd_valid,
    input wire logic tx_cmd_ready,
    output logic [iest_pkg::TX_W-1:0] tx_cmd_data,
    // Slave read and abort events
    input wire logic slave_read_req,
    input wire logic tx_abort_event,
    input wire logic [REASON_W-1:0] tx_abort_cause,
    // Status
    output logic scl_hold_low,
    output logic [15:0] raw_event_status
);
    iest_pkg::iest_events_t ev_q;
    iest_pkg::iest_events_t ev_d;
    logic [15:0] mask_q;
    logic [4:0] rx_thr_q;
    logic [4:0] tx_thr_q;
    logic [REASON_W-1:0] reason_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic scl_hold_q;
    logic tx_valid_q;
    logic [iest_pkg::TX_W-1:0] tx_data_q;
    logic setup;
    logic rd;
    logic wr;
    logic mapped;
    logic clr_all;
    logic [31:0] rd_mux;
    logic tx_flush;
    logic tx_push_try;
    logic tx_in_ready;
    logic tx_out_valid;
    logic tx_out_ready;
    logic [iest_pkg::TX_W-1:0] tx_out_data;
    logic [LW-1:0] tx_level;
    logic [LW:0] tx_fill;
    logic [LW:0] tx_limit;
    logic rx_in_ready;
    logic rx_out_valid;
    logic rx_pop;
    logic [iest_pkg::RX_W-1:0] rx_out_data;
    logic [LW-1:0] rx_level;
    logic [15:0] raw_word;

    assign setup = psel && !penable;
    assign rd = setup && !pwrite;
    assign wr = setup && pwrite;
    assign clr_all = rd && (paddr == iest_pkg::ADDR_CLR_ALL);
    assign raw_word = {{(16 - iest_pkg::EV_W){1'b0}}, ev_q};

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign scl_hold_low = scl_hold_q;
    assign raw_event_status = raw_word;
    assign tx_cmd_valid = tx_valid_q;
    assign tx_cmd_data = tx_data_q;

    assign tx_flush = !enable_bit || ev_q.tx_abort;
    assign tx_push_try = wr && (paddr == iest_pkg::ADDR_DATA_CMD) && enable_bit && !ev_q.tx_abort;
    assign tx_out_ready = !tx_valid_q || tx_cmd_ready;
    assign tx_fill = {1'b0, tx_level} + {{LW{1'b0}}, tx_valid_q};
    assign tx_limit = (tx_thr_q == 5'(DEPTH - 1)) ? (LW + 1)'(DEPTH) : (LW + 1)'(tx_thr_q);
    assign rx_pop = rd && (paddr == iest_pkg::ADDR_DATA_CMD);

    iest_fifo #(
        .WIDTH(iest_pkg::TX_W),
        .DEPTH(DEPTH)
    ) u_tx_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .flush(tx_flush),
        .in_valid(tx_push_try),
        .in_ready(tx_in_ready),
        .in_data(pwdata[iest_pkg::TX_W-1:0]),
        .out_valid(tx_out_valid),
        .out_ready(tx_out_ready),
        .out_data(tx_out_data),
        .level(tx_level)
    );

    iest_fifo #(
        .WIDTH(iest_pkg::RX_W),
        .DEPTH(DEPTH)
    ) u_rx_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .flush(!enable_bit),
        .in_valid(rx_byte.valid),
        .in_ready(rx_in_ready),
        .in_data(rx_byte.data),
        .out_valid(rx_out_valid),
        .out_ready(rx_pop),
        .out_data(rx_out_data),
        .level(rx_level)
    );

    // Output stage toward the bus
    always_ff @(posedge core_clk) begin
        if (rst || tx_flush) begin
            tx_valid_q <= 1'b0;
            tx_data_q <= '0;
        end else if (tx_out_ready) begin
            tx_valid_q <= tx_out_valid;
            if (tx_out_valid) begin
                tx_data_q <= tx_out_data;
            end
        end
    end

    // Next event flags
    always_comb begin
        ev_d = ev_q;
        if (clr_all || (rd && (paddr == iest_pkg::ADDR_CLR_RD_REQ))) begin
            ev_d.rd_req = 1'b0;
        end
        if (slave_read_req) begin
            ev_d.rd_req = 1'b1;
        end
        if (clr_all || (rd && (paddr == iest_pkg::ADDR_CLR_TRANSMIT_ABORT_FLAG))) begin
            ev_d.tx_abort = 1'b0;
        end
        if (tx_abort_event) begin
            ev_d.tx_abort = 1'b1;
        end
        if (!internal_enable_state || clr_all || (rd && (paddr == iest_pkg::ADDR_CLR_TX_OVER))) begin
            ev_d.tx_over = 1'b0;
        end
        if (tx_push_try && !tx_in_ready) begin
            ev_d.tx_over = 1'b1;
        end
        if (!internal_enable_state || clr_all || (rd && (paddr == iest_pkg::ADDR_CLR_RX_OVER))) begin
            ev_d.rx_over = 1'b0;
        end
        if (rx_byte.valid && enable_bit && !rx_in_ready) begin
            ev_d.rx_over = 1'b1;
        end
        if (!internal_enable_state || clr_all || (rd && (paddr == iest_pkg::ADDR_CLR_RX_UNDER))) begin
            ev_d.rx_under = 1'b0;
        end
        if (rx_pop && !rx_out_valid) begin
            ev_d.rx_under = 1'b1;
        end
        ev_d.tx_empty = enable_bit ? (tx_fill <= tx_limit) : sm_activity;
        // N fires at N plus one
        ev_d.rx_full = enable_bit && (rx_level >= (LW'(rx_thr_q) + LW'(1)));
    end

    // Event flag register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ev_q <= '0;
        end else begin
            ev_q <= ev_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            scl_hold_q <= 1'b0;
        end else begin
            scl_hold_q <= ev_d.rd_req;
        end
    end

    // Abort reason
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reason_q <= '0;
        end else if (tx_abort_event) begin
            reason_q <= reason_q | tx_abort_cause;
        end else if (clr_all || (rd && (paddr == iest_pkg::ADDR_CLR_TRANSMIT_ABORT_FLAG))) begin
            reason_q <= '0;
        end
    end

    // Mask register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mask_q <= iest_pkg::MASK_RESET;
        end else if (wr && (paddr == iest_pkg::ADDR_INTR_MASK)) begin
            mask_q <= pwdata[15:0];
        end
    end

    // Receive threshold
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_thr_q <= iest_pkg::THR_RESET;
        end else if (wr && (paddr == iest_pkg::ADDR_RX_THR)) begin
            rx_thr_q <= (32'(pwdata[4:0]) > 32'(DEPTH - 1)) ? 5'(DEPTH - 1) : pwdata[4:0];
        end
    end

    // Transmit threshold
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_thr_q <= iest_pkg::THR_RESET;
        end else if (wr && (paddr == iest_pkg::ADDR_TX_THR)) begin
            tx_thr_q <= (32'(pwdata[4:0]) > 32'(DEPTH - 1)) ? 5'(DEPTH - 1) : pwdata[4:0];
        end
    end

    // Read data select
    always_comb begin
        rd_mux = '0;
        mapped = 1'b1;
        unique case (paddr)
            iest_pkg::ADDR_DATA_CMD: rd_mux = 32'(rx_out_data);
            iest_pkg::ADDR_INTR_STAT: rd_mux = 32'(raw_word & mask_q);
            iest_pkg::ADDR_INTR_MASK: rd_mux = 32'(mask_q);
            iest_pkg::ADDR_RAW_STAT: rd_mux = 32'(raw_word);
            iest_pkg::ADDR_RX_THR: rd_mux = 32'(rx_thr_q);
            iest_pkg::ADDR_TX_THR: rd_mux = 32'(tx_thr_q);
            iest_pkg::ADDR_CLR_ALL: rd_mux = 32'(|(raw_word & mask_q));
            iest_pkg::ADDR_CLR_RX_UNDER: rd_mux = 32'(ev_q.rx_under);
            iest_pkg::ADDR_CLR_RX_OVER: rd_mux = 32'(ev_q.rx_over);
            iest_pkg::ADDR_CLR_TX_OVER: rd_mux = 32'(ev_q.tx_over);
            iest_pkg::ADDR_CLR_RD_REQ: rd_mux = 32'(ev_q.rd_req);
            iest_pkg::ADDR_CLR_TRANSMIT_ABORT_FLAG: rd_mux = 32'(ev_q.tx_abort);
            iest_pkg::ADDR_ABORT_REASON: rd_mux = 32'(reason_q);
            default: mapped = 1'b0;
        endcase
    end

    // APB answer, one access phase
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup && !mapped;
            if (rd) begin
                prdata_q <= rd_mux;
            end
        end
    end
endmodule // iest_event_status

//--- verif/iest_event_status_chk_sva.sv
// Purpose: Port assertions for the I2C event status block
// Assumes: One clock, synchronous active-high reset
// Notes: Raw flags may trail their cause by one extra cycle
`timescale 1ns/10ps
module iest_event_status_chk #(
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // APB request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    // Controller state
    input wire logic enable_bit,
    input wire logic internal_enable_state,
    input wire logic sm_activity,
    // Far side
    input wire iest_pkg::iest_rx_byte_t rx_byte,
    input wire logic slave_read_req,
    input wire logic tx_abort_event,
    input wire logic tx_cmd_valid,
    // Status
    input wire logic scl_hold_low,
    input wire logic [15:0] raw_event_status
);
    logic rd_setup;
    assign rd_setup = psel && !penable && !pwrite;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    chk_rdreq_set:
        assert property (slave_read_req |-> ##[1:2] raw_event_status[5])
        else $error("read request flag not raised");
    chk_scl_stall:
        assert property (slave_read_req |=> scl_hold_low)
        else $error("clock line not held low");
    chk_rdreq_clear:
        assert property (rd_setup && paddr == iest_pkg::ADDR_CLR_RD_REQ && !slave_read_req |=> !scl_hold_low)
        else $error("read request not cleared");
    chk_txempty_idle:
        assert property ((!enable_bit && !sm_activity) [*3] |-> !raw_event_status[4])
        else $error("transmit low flag set while idle");
    chk_flags_disable:
        assert property ((!internal_enable_state && !psel && !rx_byte.valid) [*3]
            |-> (raw_event_status[3] || raw_event_status[1] || raw_event_status[0]) == 1'b0)
        else $error("overflow flags kept after disable");
    chk_rxfull_off:
        assert property (!enable_bit [*3] |-> !raw_event_status[2])
        else $error("receive high flag set while disabled");
    chk_clear_all:
        assert property (rd_setup && paddr == iest_pkg::ADDR_CLR_ALL && !slave_read_req && !tx_abort_event
            && !rx_byte.valid |=> (raw_event_status[6:0] & 7'h6b) == 7'h00)
        else $error("clear all left a flag set");
    chk_abort_flush:
        assert property (raw_event_status[6] [*2] |-> !tx_cmd_valid)
        else $error("command offered during abort");
endmodule // iest_event_status_chk

//--- verif/iest_bus_model.sv
// Purpose: Behavioural bus state machine side of the event block
// Assumes: Driven at the falling edge, one pulse per event
// Notes: Released byte lines show inverted data
`timescale 1ns/10ps
module iest_bus_model (
    // Clock
    input wire logic core_clk,
    // Events
    output iest_pkg::iest_rx_byte_t rx_byte,
    output logic slave_read_req,
    output logic tx_abort_event,
    output logic [15:0] tx_abort_cause,
    // Command link
    input wire logic tx_cmd_valid,
    output logic tx_cmd_ready,
    input wire logic [iest_pkg::TX_W-1:0] tx_cmd_data
);
    logic [iest_pkg::TX_W-1:0] got_q[$];
    logic stall = 0;
    initial begin
        rx_byte = '0;
        slave_read_req = 0;
        tx_abort_event = 0;
        tx_abort_cause = '0;
        tx_cmd_ready = 0;
    end
    always @(negedge core_clk) tx_cmd_ready <= !stall;
    always @(posedge core_clk) if (tx_cmd_valid && tx_cmd_ready) got_q.push_back(tx_cmd_data);
    task automatic send(input logic [7:0] d);
        @(negedge core_clk);
        rx_byte = {1'b1, d};
        @(negedge core_clk);
        rx_byte = {1'b0, ~d};
    endtask
    task automatic req();
        @(negedge core_clk);
        slave_read_req = 1;
        @(negedge core_clk);
        slave_read_req = 0;
    endtask
    task automatic abort(input logic [15:0] c);
        @(negedge core_clk);
        tx_abort_event = 1;
        tx_abort_cause = c;
        @(negedge core_clk);
        tx_abort_event = 0;
        tx_abort_cause = ~c;
    endtask
endmodule // iest_bus_model

//--- verif/tb.sv
// Purpose: Self-checking bench for the I2C event status block
// Assumes: Bus model drives the far side at the falling edge
// Notes: Thresholds and bytes drawn from a fixed seed
`timescale 1ns/10ps
bind iest_event_status iest_event_status_chk #(.DEPTH(DEPTH)) iest_event_status_chk_inst (
    .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .enable_bit, .internal_enable_state, .sm_activity,
    .rx_byte, .slave_read_req, .tx_abort_event, .tx_cmd_valid, .scl_hold_low, .raw_event_status
);
module tb;
    localparam int D = iest_pkg::FIFO_DEPTH;
    logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
    logic enable_bit = 0, internal_enable_state = 0, sm_activity = 0, scl_hold_low;
    logic [31:0] paddr = '0, pwdata = '0, prdata, r;
    logic slave_read_req, tx_abort_event, tx_cmd_valid, tx_cmd_ready;
    logic [15:0] tx_abort_cause, raw_event_status, c;
    logic [iest_pkg::TX_W-1:0] tx_cmd_data;
    iest_pkg::iest_rx_byte_t rx_byte;
    logic [7:0] b0;
    int seed = 46, mismatches = 0, checks_done = 0, n, i, k;
    iest_event_status #(.DEPTH(D), .REASON_W(16)) iest_event_status_inst (
        .core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .enable_bit, .internal_enable_state, .sm_activity, .rx_byte, .tx_cmd_valid, .tx_cmd_ready,
        .tx_cmd_data, .slave_read_req, .tx_abort_event, .tx_abort_cause, .scl_hold_low, .raw_event_status
    );
    iest_bus_model iest_bus_model_inst (
        .core_clk, .rx_byte, .slave_read_req, .tx_abort_event, .tx_abort_cause,
        .tx_cmd_valid, .tx_cmd_ready, .tx_cmd_data
    );
    initial forever #4 core_clk = ~core_clk;
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int t);
        repeat (t) @(negedge core_clk);
    endtask
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(negedge core_clk);
        psel = 1;
        penable = 0;
        pwrite = w;
        paddr = a;
        pwdata = d;
        @(negedge core_clk);
        penable = 1;
        for (n = 0; pready !== 1'b1; n++) begin
            if (n > 4) begin
                mismatches++;
                $display("Error at %0t: no ready from the register port", $time);
                give_verdict();
            end
            @(negedge core_clk);
        end
        r = prdata;
        e = pslverr;
        @(negedge core_clk);
        psel = 0;
        penable = 0;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1, a, d);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        ck(r, exp);
    endtask
    function automatic logic [31:0] clamp(input int v);
        return (v > D - 1) ? D - 1 : v;
    endfunction
    initial begin
        tick(5);
        rst = 0;
        rd(iest_pkg::ADDR_RX_THR, 0);
        rd(iest_pkg::ADDR_TX_THR, 0);
        rd(iest_pkg::ADDR_INTR_MASK, iest_pkg::MASK_RESET);
        ck(raw_event_status, 0);
        apb(0, 32'h50001400, 0);
        ck(e, 1);
        for (i = 0; i < 4; i++) begin
            k = (i == 0) ? 63 : {$random(seed)} % 32;
            wr(iest_pkg::ADDR_RX_THR, k);
            rd(iest_pkg::ADDR_RX_THR, clamp(k));
            wr(iest_pkg::ADDR_TX_THR, k);
            rd(iest_pkg::ADDR_TX_THR, clamp(k));
        end
        $display("register test done");
        enable_bit = 1;
        internal_enable_state = 1;
        sm_activity = 1;
        k = {$random(seed)} % 6;
        b0 = $random(seed);
        wr(iest_pkg::ADDR_RX_THR, k);
        for (i = 0; i <= k; i++) begin
            tick(2);
            ck(raw_event_status[2], 0);
            iest_bus_model_inst.send(8'(b0 + i));
        end
        tick(2);
        ck(raw_event_status[2], 1);
        rd(iest_pkg::ADDR_DATA_CMD, b0);
        tick(2);
        ck(raw_event_status[2], 0);
        iest_bus_model_inst.send(b0);
        enable_bit = 0;
        tick(2);
        ck(raw_event_status[2], 0);
        enable_bit = 1;
        apb(0, iest_pkg::ADDR_DATA_CMD, 0);
        tick(2);
        ck(raw_event_status[0], 1);
        rd(iest_pkg::ADDR_CLR_RX_UNDER, 1);
        ck(raw_event_status[0], 0);
        apb(0, iest_pkg::ADDR_DATA_CMD, 0);
        apb(0, iest_pkg::ADDR_CLR_ALL, 0);
        tick(2);
        ck(raw_event_status[4:0], 5'h10);
        c = $random(seed);
        wr(iest_pkg::ADDR_INTR_MASK, c);
        rd(iest_pkg::ADDR_INTR_STAT, c & 16'h0010);
        rd(iest_pkg::ADDR_CLR_ALL, c[4]);
        $display("receive test done");
        iest_bus_model_inst.req();
        tick(1);
        ck({scl_hold_low, raw_event_status[5]}, 2'b11);
        b0 = $random(seed);
        wr(iest_pkg::ADDR_DATA_CMD, b0);
        rd(iest_pkg::ADDR_CLR_RD_REQ, 1);
        tick(1);
        ck({scl_hold_low, raw_event_status[5]}, 0);
        ck(iest_bus_model_inst.got_q.size(), 1);
        ck(iest_bus_model_inst.got_q.pop_front(), b0);
        $display("read request test done");
        iest_bus_model_inst.stall = 1;
        k = {$random(seed)} % 4;
        wr(iest_pkg::ADDR_TX_THR, k);
        for (i = 1; i <= D + 2; i++) begin
            wr(iest_pkg::ADDR_DATA_CMD, i);
            tick(1);
            if (i <= k + 1) ck(raw_event_status[4], i <= k);
            if (i == D) ck(raw_event_status[3], 0);
        end
        ck(raw_event_status[3], 1);
        rd(iest_pkg::ADDR_CLR_TX_OVER, 1);
        ck(raw_event_status[3], 0);
        wr(iest_pkg::ADDR_DATA_CMD, 32'h1aa);
        ck(raw_event_status[3], 1);
        enable_bit = 0;
        tick(3);
        ck(raw_event_status[4:3], 2'b11);
        sm_activity = 0;
        internal_enable_state = 0;
        tick(3);
        ck(raw_event_status[4:3], 0);
        iest_bus_model_inst.stall = 0;
        tick(3);
        ck(iest_bus_model_inst.got_q.size(), 0);
        $display("transmit test done");
        enable_bit = 1;
        internal_enable_state = 1;
        sm_activity = 1;
        for (i = 0; i <= D; i++) begin
            if (i == D) ck(raw_event_status[1], 0);
            iest_bus_model_inst.send(8'(i));
        end
        tick(2);
        ck(raw_event_status[1], 1);
        rd(iest_pkg::ADDR_DATA_CMD, 0);
        rd(iest_pkg::ADDR_CLR_RX_OVER, 1);
        ck(raw_event_status[1], 0);
        $display("overflow test done");
        c = $random(seed);
        iest_bus_model_inst.stall = 1;
        wr(iest_pkg::ADDR_DATA_CMD, 32'haa);
        iest_bus_model_inst.abort(c);
        tick(1);
        ck(raw_event_status[6], 1);
        iest_bus_model_inst.stall = 0;
        rd(iest_pkg::ADDR_ABORT_REASON, c);
        wr(iest_pkg::ADDR_DATA_CMD, 32'h55);
        tick(3);
        ck(iest_bus_model_inst.got_q.size(), 0);
        rd(iest_pkg::ADDR_CLR_TRANSMIT_ABORT_FLAG, 1);
        rd(iest_pkg::ADDR_ABORT_REASON, 0);
        wr(iest_pkg::ADDR_DATA_CMD, 32'h55);
        tick(3);
        ck(iest_bus_model_inst.got_q.size(), 1);
        iest_bus_model_inst.abort(c);
        apb(0, iest_pkg::ADDR_CLR_ALL, 0);
        rd(iest_pkg::ADDR_ABORT_REASON, 0);
        $display("abort test done");
        give_verdict();
    end
endmodule // tb
